/* verilog/usf_top.v */
// Status flags, modem mirror, receive holding data and AHB-Lite registers
`timescale 1ns/10ps
`include "usf_map.vh"
module usf_top (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        clk_en,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Transmitter side
  input  wire        tx_ready_in,
  input  wire        tx_char_loaded,
  input  wire        tx_shift_empty,
  // Receiver side
  input  wire        rx_char_valid,
  input  wire [7:0]  rx_char,
  input  wire        rx_parity_error,
  input  wire        rx_first_stop_ok,
  input  wire        rx_load_holding,
  // Modem lines, active low
  input  wire        carrier_detect_n,
  input  wire        set_ready_n,
  // Pins and interrupt
  output wire        tx_empty_modem_change_pin_n,
  output wire        irq
);

  // Bus pipeline and answer registers
  reg        dphase_q;
  reg        dwrite_q;
  reg [7:0]  daddr_q;
  reg [31:0] hrdata_q;
  reg        hreadyout_q;

  // Software-written configuration
  reg [`USF_CR_WIDTH-1:0] control_q;
  reg [23:0]              chars_q;
  reg [`USF_IRQ_WIDTH-1:0] irq_mask_q;
  reg [`USF_IRQ_WIDTH-1:0] irq_status_q;
  reg [`USF_IRQ_WIDTH-1:0] irq_status_d;
  reg                      irq_q;
  reg                      clr_errors_q;

  // Flags
  reg tx_empty_or_modem_change_flag_q;
  reg tx_armed_q;
  reg receive_ready_flag_q;
  reg parity_or_dle_flag_q;
  reg overrun_flag_q;
  reg framing_or_sync_flag_q;
  reg [7:0] rx_holding_q;
  reg pin_n_q;
  reg prev_tx_enable_q;

  wire [1:0] modem_flag;
  wire       modem_change;
  wire       parity_dle_evt;
  wire       frame_sync_evt;
  wire [7:0] line_status_flags;
  reg  [31:0] read_mux;

  // Decoded control fields and modem level flags
  wire transmit_enable_bit = control_q[`USF_CR_TX_ENABLE];
  wire rx_enable           = control_q[`USF_CR_RX_ENABLE];
  wire sync_mode           = control_q[`USF_CR_SYNC_MODE];
  wire parity_enable_bit   = control_q[`USF_CR_PARITY_EN];
  wire transparency_bit    = control_q[`USF_CR_TRANSPARENT];
  wire single_sync         = control_q[`USF_CR_SINGLE_SYNC];
  wire carrier_detect_flag = modem_flag[0];
  wire set_ready_flag      = modem_flag[1];

  // Address phase accepted when selected, nonsequential and bus ready
  wire addr_ok  = clk_en & hsel & hready & (htrans == `USF_HTRANS_NONSEQ);
  wire rd_take  = addr_ok & ~hwrite;
  wire wr_take  = clk_en & dphase_q & dwrite_q;

  // Register side effects of reads happen at address-phase acceptance
  wire status_read = rd_take & (haddr == `USF_OFS_STATUS);
  wire rxdata_read = rd_take & (haddr == `USF_OFS_RX_DATA);
  wire ctrl_write  = wr_take & (daddr_q == `USF_OFS_CONTROL);
  wire chars_write = wr_take & (daddr_q == `USF_OFS_CHARS);
  wire ims_write   = wr_take & (daddr_q == `USF_OFS_IRQ_STATUS);
  wire msk_write   = wr_take & (daddr_q == `USF_OFS_IRQ_MASK);

  // Transmitter enable edge, used to clear and disarm the empty flag
  wire tx_enable_rise = transmit_enable_bit & ~prev_tx_enable_q;

  // no sync-mode exclusion: fill characters do not suppress the event
  // empty condition only counts once a character has gone out
  wire tx_empty_evt = clk_en & tx_shift_empty & tx_armed_q & transmit_enable_bit;
  wire tx_flag_set  = tx_empty_evt | modem_change;
  wire rx_load      = clk_en & rx_load_holding & rx_enable;
  // overrun on load while previous character unread
  wire overrun_evt  = rx_load & receive_ready_flag_q & ~rxdata_read;
  wire err_evt      = parity_dle_evt | overrun_evt | frame_sync_evt;

  assign line_status_flags = {set_ready_flag, carrier_detect_flag,
                              framing_or_sync_flag_q, overrun_flag_q,
                              parity_or_dle_flag_q, tx_empty_or_modem_change_flag_q,
                              receive_ready_flag_q, tx_ready_in};

  usf_modem_watch u_modem (
    .core_clk   (core_clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .modem_n    ({set_ready_n, carrier_detect_n}),
    .level_flag (modem_flag),
    .change_evt (modem_change)
  );

  usf_rx_check u_check (
    .core_clk         (core_clk),
    .reset            (reset),
    .clk_en           (clk_en),
    .rx_enable        (rx_enable),
    .sync_mode        (sync_mode),
    .parity_en        (parity_enable_bit),
    .transparent      (transparency_bit),
    .single_sync      (single_sync),
    .first_sync_char  (chars_q[`USF_CH_SYNC1_LSB +: 8]),
    .second_sync_char (chars_q[`USF_CH_SYNC2_LSB +: 8]),
    .dle_char         (chars_q[`USF_CH_DLE_LSB +: 8]),
    .char_valid       (rx_char_valid),
    .char_data        (rx_char),
    .parity_error     (rx_parity_error),
    .first_stop_ok    (rx_first_stop_ok),
    .parity_dle_evt   (parity_dle_evt),
    .frame_sync_evt   (frame_sync_evt)
  );

  // Bus pipeline: remember the address phase for the write data phase
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dphase_q    <= 1'b0;
      dwrite_q    <= 1'b0;
      daddr_q     <= 8'h00;
      hreadyout_q <= 1'b0;
    end else if (clk_en) begin
      hreadyout_q <= 1'b1;            // zero wait states once out of reset
      if (hready) begin
        dphase_q <= addr_ok;
        dwrite_q <= addr_ok & hwrite;
        daddr_q  <= haddr;
      end
    end
  end

  // Read mux; unmapped offsets read zero with an OKAY answer
  always @* begin
    read_mux = 32'h0000_0000;
    case (haddr)
      `USF_OFS_STATUS:     read_mux[7:0] = line_status_flags;
      `USF_OFS_CONTROL:    read_mux[`USF_CR_WIDTH-1:0] = control_q;
      `USF_OFS_CHARS:      read_mux[23:0] = chars_q;
      `USF_OFS_RX_DATA:    read_mux[7:0] = rx_holding_q;
      `USF_OFS_IRQ_STATUS: read_mux[`USF_IRQ_WIDTH-1:0] = irq_status_q;
      `USF_OFS_IRQ_MASK:   read_mux[`USF_IRQ_WIDTH-1:0] = irq_mask_q;
      default:             read_mux = 32'h0000_0000;
    endcase
  end

  // Read data latched at the address edge so it stands through the data phase
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_q <= read_mux;
    end
  end

  // Control and character registers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      control_q    <= `USF_RST_CONTROL;
      chars_q      <= `USF_RST_CHARS;
      irq_mask_q   <= `USF_RST_IRQ_MASK;
      clr_errors_q <= 1'b0;
      prev_tx_enable_q <= 1'b0;
    end else if (clk_en) begin
      prev_tx_enable_q <= transmit_enable_bit;
      // clear-errors self clears; control_q never stores a one in its bit
      clr_errors_q <= ctrl_write & hwdata[`USF_CR_CLR_ERRORS];
      if (ctrl_write) begin
        control_q <= hwdata[`USF_CR_WIDTH-1:0] &
                     ~(7'h01 << `USF_CR_CLR_ERRORS);
      end
      if (chars_write) begin
        chars_q <= hwdata[23:0];
      end
      if (msk_write) begin
        irq_mask_q <= hwdata[`USF_IRQ_WIDTH-1:0];
      end
      // no branch writes the status offset
    end
  end

  // Transmit-empty / modem-change flag and its arming
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_empty_or_modem_change_flag_q <= 1'b0;
      tx_armed_q <= 1'b0;
    end else if (clk_en) begin
      // enable disarms until a character leaves the holding register
      if (tx_enable_rise) begin
        tx_armed_q <= 1'b0;
      end else if (tx_char_loaded) begin
        tx_armed_q <= 1'b1;
      end
      // set wins over clear so a coincident event is not lost
      if (tx_flag_set) begin
        tx_empty_or_modem_change_flag_q <= 1'b1;
      end else if (status_read | tx_enable_rise) begin
        tx_empty_or_modem_change_flag_q <= 1'b0;
      end
    end
  end

  // Receive holding data and receive-ready flag
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_holding_q         <= 8'h00;
      receive_ready_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (rx_load) begin
        rx_holding_q <= rx_char;
      end
      // disable dominates; a load beats a coincident read
      if (~rx_enable) begin
        receive_ready_flag_q <= 1'b0;
      end else if (rx_load) begin
        receive_ready_flag_q <= 1'b1;
      end else if (rxdata_read) begin
        receive_ready_flag_q <= 1'b0;
      end
    end
  end

  // Error flags; a disabled receiver holds them clear
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      parity_or_dle_flag_q   <= 1'b0;
      overrun_flag_q         <= 1'b0;
      framing_or_sync_flag_q <= 1'b0;
    end else if (clk_en) begin
      // receiver off clears; clear command loses to a new event
      if (~rx_enable) begin
        parity_or_dle_flag_q <= 1'b0;
        overrun_flag_q       <= 1'b0;
      end else begin
        if (parity_dle_evt) begin
          parity_or_dle_flag_q <= 1'b1;
        end else if (clr_errors_q) begin
          parity_or_dle_flag_q <= 1'b0;
        end
        if (overrun_evt) begin
          overrun_flag_q <= 1'b1;
        end else if (clr_errors_q) begin
          overrun_flag_q <= 1'b0;
        end
      end
      // clear source depends on the major mode
      if (~rx_enable) begin
        framing_or_sync_flag_q <= 1'b0;
      end else if (frame_sync_evt) begin
        framing_or_sync_flag_q <= 1'b1;
      end else if (sync_mode ? status_read : clr_errors_q) begin
        framing_or_sync_flag_q <= 1'b0;
      end
    end
  end

  // Interrupt status: sticky, write one to clear, new events win
  always @* begin
    irq_status_d = irq_status_q;
    if (ims_write) begin
      irq_status_d = irq_status_q & ~hwdata[`USF_IRQ_WIDTH-1:0];
    end
    if (tx_flag_set) begin
      irq_status_d[`USF_IRQ_TX_EMPTY] = 1'b1;
    end
    if (rx_load) begin
      irq_status_d[`USF_IRQ_RX_READY] = 1'b1;
    end
    if (err_evt) begin
      irq_status_d[`USF_IRQ_ERROR] = 1'b1;
    end
  end

  // Interrupt and pin outputs registered so they never glitch
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_status_q <= 3'h0;
      irq_q        <= 1'b0;
      pin_n_q      <= 1'b1;
    end else if (clk_en) begin
      irq_status_q <= irq_status_d;
      irq_q        <= |(irq_status_d & irq_mask_q);
      // pin low while the flag is set; one cycle behind the set
      pin_n_q      <= ~tx_empty_or_modem_change_flag_q;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;        // Always OKAY
  assign irq       = irq_q;
  assign tx_empty_modem_change_pin_n = pin_n_q;

endmodule // usf_top

/* verilog/usf_map.vh */
// Register offsets, field positions and reset values of the status-flag block
`ifndef USF_MAP_VH
`define USF_MAP_VH

// Byte offsets on the AHB-Lite register port
`define USF_OFS_STATUS      8'h00
`define USF_OFS_CONTROL     8'h04
`define USF_OFS_CHARS       8'h08
`define USF_OFS_RX_DATA     8'h0C
`define USF_OFS_IRQ_STATUS  8'h10
`define USF_OFS_IRQ_MASK    8'h14

// Status register bit positions
`define USF_SR_TX_READY     0
`define USF_SR_RX_READY     1
`define USF_SR_TX_EMPTY     2
`define USF_SR_PARITY_DLE   3
`define USF_SR_OVERRUN      4
`define USF_SR_FRAME_SYNC   5
`define USF_SR_CARRIER      6
`define USF_SR_SET_READY    7

// Control register bit positions
`define USF_CR_TX_ENABLE    0
`define USF_CR_RX_ENABLE    1
`define USF_CR_CLR_ERRORS   2
`define USF_CR_SYNC_MODE    3
`define USF_CR_PARITY_EN    4
`define USF_CR_TRANSPARENT  5
`define USF_CR_SINGLE_SYNC  6
`define USF_CR_WIDTH        7

// Character register fields: first sync, second sync, DLE
`define USF_CH_SYNC1_LSB    0
`define USF_CH_SYNC2_LSB    8
`define USF_CH_DLE_LSB      16

// Interrupt status bits
`define USF_IRQ_TX_EMPTY    0
`define USF_IRQ_RX_READY    1
`define USF_IRQ_ERROR       2
`define USF_IRQ_WIDTH       3

// Reset values
`define USF_RST_CONTROL     7'h00
`define USF_RST_CHARS       24'h10_1616
`define USF_RST_IRQ_MASK    3'h0

// AHB encodings
`define USF_HTRANS_NONSEQ   2'h2

`endif

/* verilog/usf_modem_watch.v */
// Samples the modem inputs, mirrors them as flags and flags any change
`timescale 1ns/10ps
module usf_modem_watch (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       clk_en,
  input  wire [1:0] modem_n,
  output wire [1:0] level_flag,
  output wire       change_evt
);

  reg  [1:0] sample_q;
  reg        primed_q;
  wire [1:0] diff;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_line
      // mirror modem lines: low input reads as a set flag
      always @(posedge core_clk or posedge reset) begin
        if (reset) begin
          sample_q[i] <= 1'b1;
        end else if (clk_en) begin
          sample_q[i] <= modem_n[i];
        end
      end
      assign level_flag[i] = ~sample_q[i];
      assign diff[i]       = sample_q[i] ^ modem_n[i];
    end
  endgenerate

  // First sample after reset is not a change; the preset level is a guess
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      primed_q <= 1'b0;
    end else if (clk_en) begin
      primed_q <= 1'b1;
    end
  end

  assign change_evt = primed_q & clk_en & (|diff);

endmodule // usf_modem_watch

/* verilog/usf_rx_check.v */
// Classifies each assembled character into error and sync/DLE events
`timescale 1ns/10ps
module usf_rx_check (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       clk_en,
  input  wire       rx_enable,
  input  wire       sync_mode,
  input  wire       parity_en,
  input  wire       transparent,
  input  wire       single_sync,
  input  wire [7:0] first_sync_char,
  input  wire [7:0] second_sync_char,
  input  wire [7:0] dle_char,
  input  wire       char_valid,
  input  wire [7:0] char_data,
  input  wire       parity_error,
  input  wire       first_stop_ok,
  output wire       parity_dle_evt,
  output wire       frame_sync_evt
);

  reg  prev_dle_q;
  reg  prev_sync1_q;
  reg  synced_q;
  wire is_dle   = char_data == dle_char;
  wire is_sync1 = char_data == first_sync_char;
  wire is_sync2 = char_data == second_sync_char;
  wire sync_hit = single_sync ? is_sync1 : (prev_sync1_q & is_sync2);
  wire strobe   = char_valid & rx_enable & clk_en;

  // parity error; first DLE of a pair only
  assign parity_dle_evt = strobe & (parity_en ? parity_error :
                          (sync_mode & transparent & is_dle & ~prev_dle_q));

  // async stop bit; sync pattern; transparent DLE-sync
  assign frame_sync_evt = strobe & (~sync_mode ? ~first_stop_ok :
                          (~transparent ? sync_hit :
                          (synced_q ? (prev_dle_q & is_sync1) : sync_hit)));

  // History of the last character; a DLE pair consumes both characters
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_dle_q   <= 1'b0;
      prev_sync1_q <= 1'b0;
      synced_q     <= 1'b0;
    end else if (clk_en) begin
      if (~rx_enable) begin
        prev_dle_q   <= 1'b0;
        prev_sync1_q <= 1'b0;
        synced_q     <= 1'b0;
      end else if (char_valid) begin
        prev_dle_q   <= is_dle & ~prev_dle_q;
        prev_sync1_q <= is_sync1;
        if (sync_mode & sync_hit) begin
          synced_q <= 1'b1;
        end
      end
    end
  end

endmodule // usf_rx_check

/* verification/usf_top_properties.sv */
// Port-level assertions for the status-flag block
`timescale 1ns/10ps
`include "usf_map.vh"
module usf_top_properties (
  input wire        core_clk,
  input wire        reset,
  input wire        clk_en,
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        tx_shift_empty,
  input wire        carrier_detect_n,
  input wire        set_ready_n,
  input wire        tx_empty_modem_change_pin_n
);
  logic [2:0] quiet_q;
  logic       cd_q;
  logic       sr_q;
  wire        pin_n  = tx_empty_modem_change_pin_n;
  wire        rd_any = hsel && hready && htrans == `USF_HTRANS_NONSEQ && !hwrite && clk_en;
  wire        rd_st  = rd_any && haddr == `USF_OFS_STATUS;
  wire        rd_ctl = rd_any && haddr == `USF_OFS_CONTROL;
  wire        calm   = !tx_shift_empty && cd_q == carrier_detect_n && sr_q == set_ready_n;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Cycles since the last possible flag cause; saturates so it never wraps into a false calm
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      quiet_q <= 3'h0;
      cd_q    <= 1'b1;
      sr_q    <= 1'b1;
    end else if (clk_en) begin
      cd_q    <= carrier_detect_n;
      sr_q    <= set_ready_n;
      if (!calm) quiet_q <= 3'h0;
      else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
    end
  end

  // A status read with nothing pending for a while
  sequence s_quiet_read;
    rd_st && calm && quiet_q >= 3'h5;
  endsequence

  property p_pin_released;
    s_quiet_read ##1 clk_en |-> ##1 pin_n;
  endproperty
  property p_reread_clear;
    s_quiet_read ##1 calm ##1 (rd_st && calm) |=> !hrdata[`USF_SR_TX_EMPTY];
  endproperty
  property p_modem_sets;
    quiet_q >= 3'h5 && cd_q != carrier_detect_n && clk_en |-> ##[1:6] !pin_n;
  endproperty
  property p_pin_cause;
    $fell(pin_n) |-> quiet_q != 3'h7;
  endproperty
  property p_carrier_mirror;
    s_quiet_read |=> hrdata[`USF_SR_CARRIER] == !$past(carrier_detect_n);
  endproperty
  property p_ready_mirror;
    s_quiet_read |=> hrdata[`USF_SR_SET_READY] == !$past(set_ready_n);
  endproperty
  property p_clr_self;
    rd_ctl |=> !hrdata[`USF_CR_CLR_ERRORS];
  endproperty
  property p_status_width;
    rd_st |=> hrdata[31:8] == 24'h0;
  endproperty

  a_pin_released: assert property (p_pin_released) else $error("pin still low after read");
  a_reread_clear: assert property (p_reread_clear) else $error("tx empty not cleared");
  a_modem_sets: assert property (p_modem_sets) else $error("modem change not flagged");
  a_pin_cause: assert property (p_pin_cause) else $error("pin fell without cause");
  a_carrier_mirror: assert property (p_carrier_mirror) else $error("carrier bit wrong");
  a_ready_mirror: assert property (p_ready_mirror) else $error("set ready bit wrong");
  a_clr_self: assert property (p_clr_self) else $error("clear errors bit stuck");
  a_status_width: assert property (p_status_width) else $error("status upper bits set");
endmodule // usf_top_properties

/* verification/usf_line_model.sv */
// Far side: modem data set plus transmitter and receiver event sources
`timescale 1ns/10ps
module usf_line_model (
  input  wire logic       core_clk,
  output logic            carrier_detect_n,
  output logic            set_ready_n,
  output logic            tx_char_loaded,
  output logic            tx_shift_empty,
  output logic            rx_char_valid,
  output logic [7:0]      rx_char,
  output logic            rx_parity_error,
  output logic            rx_first_stop_ok,
  output logic            rx_load_holding
);
  // Modem idles high, strobes idle low
  initial begin
    carrier_detect_n = 1'b1;
    set_ready_n      = 1'b1;
    tx_char_loaded   = 1'b0;
    tx_shift_empty   = 1'b0;
    rx_char_valid    = 1'b0;
    rx_char          = 8'h00;
    rx_parity_error  = 1'b0;
    rx_first_stop_ok = 1'b1;
    rx_load_holding  = 1'b0;
  end

  // Modem lines change just after an edge
  task modem(input logic cd_n, input logic sr_n);
    carrier_detect_n <= cd_n;
    set_ready_n      <= sr_n;
  endtask

  // One transmitter pulse: 0 moves holding to shift, 1 reports shift empty
  task tx_event(input logic kind);
    tx_char_loaded <= !kind;
    tx_shift_empty <= kind;
    @(posedge core_clk);
    tx_char_loaded <= 1'b0;
    tx_shift_empty <= 1'b0;
    #1;
  endtask

  // One character; qualifiers turn to garbage once released so stale values never help
  task rx_send(input logic [7:0] c, input logic pe, input logic sok, input logic ld);
    rx_char_valid    <= 1'b1;
    rx_char          <= c;
    rx_parity_error  <= pe;
    rx_first_stop_ok <= sok;
    rx_load_holding  <= ld;
    @(posedge core_clk);
    rx_char_valid    <= 1'b0;
    rx_load_holding  <= 1'b0;
    rx_char          <= ~c;
    rx_parity_error  <= !pe;
    rx_first_stop_ok <= !sok;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
endmodule // usf_line_model

/* verification/usf_testbench.sv */
// Self-checking bench for the status-flag block
`timescale 1ns/10ps
`include "usf_map.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
  localparam logic [7:0]  A_ST = `USF_OFS_STATUS, A_CT = `USF_OFS_CONTROL;
  localparam logic [7:0]  A_CH = `USF_OFS_CHARS, A_RX = `USF_OFS_RX_DATA;
  localparam logic [7:0]  A_IS = `USF_OFS_IRQ_STATUS, A_IM = `USF_OFS_IRQ_MASK;
  localparam logic [23:0] CH = `USF_RST_CHARS;
  localparam int          TE = `USF_SR_TX_EMPTY, PD = `USF_SR_PARITY_DLE, FS = `USF_SR_FRAME_SYNC;
  localparam logic [31:0] TX = 32'h1 << `USF_CR_TX_ENABLE, RX = 32'h1 << `USF_CR_RX_ENABLE;
  localparam logic [31:0] CE = 32'h1 << `USF_CR_CLR_ERRORS, SY = 32'h1 << `USF_CR_SYNC_MODE;
  localparam logic [31:0] PE = 32'h1 << `USF_CR_PARITY_EN, TP = 32'h1 << `USF_CR_TRANSPARENT;
  localparam logic [31:0] SS = 32'h1 << `USF_CR_SINGLE_SYNC, IT = 32'h1 << `USF_IRQ_TX_EMPTY;
  logic        core_clk, reset, hsel, hwrite, ce, txr;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, r;
  wire  [31:0] hrdata;
  wire  [7:0]  rx_c;
  wire         hready, hresp, pin_n, irq, cd_n, sr_n, tx_ld, tx_se, rx_v, rx_pe, rx_sok, rx_ld;
  int          failures, num_checks, cycles;

  usf_top dut_u (.core_clk(core_clk), .reset(reset), .clk_en(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .tx_ready_in(txr),
    .tx_char_loaded(tx_ld), .tx_shift_empty(tx_se), .rx_char_valid(rx_v), .rx_char(rx_c),
    .rx_parity_error(rx_pe), .rx_first_stop_ok(rx_sok), .rx_load_holding(rx_ld),
    .carrier_detect_n(cd_n), .set_ready_n(sr_n), .tx_empty_modem_change_pin_n(pin_n),
    .irq(irq));
  usf_line_model line_u (.core_clk(core_clk), .carrier_detect_n(cd_n), .set_ready_n(sr_n),
    .tx_char_loaded(tx_ld), .tx_shift_empty(tx_se), .rx_char_valid(rx_v), .rx_char(rx_c),
    .rx_parity_error(rx_pe), .rx_first_stop_ok(rx_sok), .rx_load_holding(rx_ld));

  // Clock at 250 MHz
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Wait whole cycles, then step past the edge so outputs have settled
  task idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One AHB-Lite single transfer; read data lands in r
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= `USF_HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwdata = 32'h0;
    ce = 1'b1;
    txr = 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    idle(3);
    // Reset values and an unmapped address
    xfer(A_CT, 1'b0, 32'h0); `CHK(r, 32'h0)
    xfer(A_CH, 1'b0, 32'h0); `CHK(r, {8'h00, CH})
    xfer(A_IM, 1'b0, 32'h0); `CHK(r, 32'h0)
    xfer(8'h1C, 1'b0, 32'h0); `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    // Modem change raises the flag and pin; a read drops both
    line_u.modem(1'b0, 1'b1);
    idle(6); `CHK(pin_n, 1'b0)
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[7:0] & 8'hC4, 8'h44)
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[TE], 1'b0)
    idle(2); `CHK(pin_n, 1'b1)
    line_u.modem(1'b1, 1'b0);
    idle(6);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[7:6], 2'b10)
    // Transmitter enable clears the flag; no report before a character has gone
    line_u.modem(1'b0, 1'b0);
    idle(6);
    xfer(A_CT, 1'b1, TX | SY);
    idle(1);
    line_u.tx_event(1'b1);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[TE], 1'b0)
    line_u.tx_event(1'b0);
    line_u.tx_event(1'b1);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[TE], 1'b1)
    // Interrupt raised, masked and cleared
    xfer(A_IM, 1'b1, IT);
    idle(2); `CHK(irq, 1'b1)
    xfer(A_IM, 1'b1, 32'h0);
    idle(2); `CHK(irq, 1'b0)
    xfer(A_IM, 1'b1, IT);
    xfer(A_IS, 1'b1, IT);
    idle(2); `CHK(irq, 1'b0)
    // Status writes are ignored
    xfer(A_ST, 1'b1, 32'hFF);
    idle(1);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[7:0], 8'hC1)
    // Parity, overrun, receive ready and clear-errors in async mode
    xfer(A_CT, 1'b1, RX | PE);
    idle(1);
    line_u.rx_send(8'h5A, 1'b1, 1'b1, 1'b1);
    line_u.rx_send(8'hA5, 1'b0, 1'b1, 1'b1);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[4:1], 4'hD)
    xfer(A_RX, 1'b0, 32'h0); `CHK(r[7:0], 8'hA5)
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[1], 1'b0)
    xfer(A_CT, 1'b1, RX | PE | CE);
    idle(2);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[4:3], 2'b00)
    xfer(A_CT, 1'b0, 32'h0); `CHK(r[`USF_CR_CLR_ERRORS], 1'b0)
    // Framing survives a status read in async mode, not clear-errors
    line_u.rx_send(8'h33, 1'b0, 1'b0, 1'b0);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[FS], 1'b1)
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[FS], 1'b1)
    xfer(A_CT, 1'b1, RX | CE);
    idle(2);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[FS], 1'b0)
    // Transparent sync: initial sync, DLE pair, DLE then first sync
    xfer(A_CT, 1'b1, RX | SY | TP);
    idle(1);
    line_u.rx_send(CH[7:0], 1'b0, 1'b1, 1'b0);
    line_u.rx_send(CH[15:8], 1'b0, 1'b1, 1'b0);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[FS], 1'b1)
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[FS], 1'b0)
    line_u.rx_send(CH[23:16], 1'b0, 1'b1, 1'b0);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[PD], 1'b1)
    xfer(A_CT, 1'b1, RX | SY | TP | CE);
    idle(2);
    line_u.rx_send(CH[23:16], 1'b0, 1'b1, 1'b0);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[PD], 1'b0)
    line_u.rx_send(CH[23:16], 1'b0, 1'b1, 1'b0);
    line_u.rx_send(CH[7:0], 1'b0, 1'b1, 1'b0);
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[FS], 1'b1)
    // Non-transparent double then single sync; receiver off first drops old history
    xfer(A_CT, 1'b1, SY);
    for (int s = 0; s < 2; s++) begin
      xfer(A_CT, 1'b1, RX | SY | (s != 0 ? SS : 32'h0));
      idle(1);
      line_u.rx_send(CH[7:0], 1'b0, 1'b1, 1'b0);
      if (s == 0) begin
        xfer(A_ST, 1'b0, 32'h0); `CHK(r[FS], 1'b0)
        line_u.rx_send(CH[15:8], 1'b0, 1'b1, 1'b0);
      end
      xfer(A_ST, 1'b0, 32'h0); `CHK(r[FS], 1'b1)
    end
    // Receiver disable wipes ready, overrun and sync flags
    line_u.rx_send(CH[7:0], 1'b0, 1'b1, 1'b1);
    line_u.rx_send(CH[7:0], 1'b0, 1'b1, 1'b1);
    xfer(A_CT, 1'b1, SY);
    idle(2);
    xfer(A_ST, 1'b0, 32'h0); `CHK({r[5:3], r[1]}, 4'h0)
    // Frozen clock enable holds off a modem change until it runs again
    ce <= 1'b0;
    txr <= 1'b0;
    line_u.modem(1'b1, 1'b0);
    idle(4); `CHK(pin_n, 1'b1)
    ce <= 1'b1;
    idle(4); `CHK(pin_n, 1'b0)
    xfer(A_ST, 1'b0, 32'h0); `CHK(r[7:0], 8'h84)
    end_of_test();
  end
endmodule // testbench

bind usf_top usf_top_properties chk_u (.core_clk, .reset, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .tx_shift_empty, .carrier_detect_n, .set_ready_n,
  .tx_empty_modem_change_pin_n);
